// ===== design/ovp_pkg.sv
// Constants shared by the three-stage overvoltage block and its setting store.
// Assumes a single 250 MHz protection clock and voltages in units of 0.01 V secondary.
package ovp_pkg;

    // Register port widths, stage, group and parameter counts, and setting store address width.
    localparam int unsigned DW   = 16;
    localparam int unsigned AW   = 8;
    localparam int unsigned NST  = 3;
    localparam int unsigned NGRP = 4;
    localparam int unsigned NPAR = 4;
    localparam int unsigned MAW  = 6;

    // Parameter index inside one stage's setting block.
    localparam logic [1:0] PAR_START  = 2'h0;
    localparam logic [1:0] PAR_HYST   = 2'h1;
    localparam logic [1:0] PAR_OPDLY  = 2'h2;
    localparam logic [1:0] PAR_RELDLY = 2'h3;

    // Register word addresses; settings occupy words 0 to 11 of each 16-word group below SET_END.
    localparam logic [7:0] SET_END    = 8'h40;
    localparam logic [7:0] REG_CTRL   = 8'h40;
    localparam logic [7:0] REG_VNSEC  = 8'h41;
    localparam logic [7:0] REG_STATUS = 8'h42;

    // Control and status register fields, control and rated voltage reset values.
    localparam int unsigned CTRL_GRP_LSB  = 0;
    localparam int unsigned CTRL_EN_LSB   = 2;
    localparam int unsigned STAT_TRIP_LSB = 4;
    localparam logic [15:0] CTRL_RST      = 16'h001C;
    localparam logic [15:0] VNSEC_RST     = 16'h0064;

    // Setting reset values: start 110 %, hysteresis 3.0 %, operate 1.00 s, release 0.06 s.
    localparam logic [15:0] START_RST  = 16'h006E;
    localparam logic [15:0] HYST_RST   = 16'h001E;
    localparam logic [15:0] OPDLY_RST  = 16'h0064;
    localparam logic [15:0] RELDLY_RST = 16'h0006;

    // Setting ranges: percent of rated voltage, tenths of a percent, 10 ms ticks.
    localparam logic [15:0] START_MIN      = 16'h0032;
    localparam logic [15:0] START_MAX_LOW  = 16'h0096;
    localparam logic [15:0] START_MAX_HIGH = 16'h00A0;
    localparam logic [15:0] MEAS_LIMIT     = 16'h3E80;
    localparam logic [15:0] HYST_MIN       = 16'h0001;
    localparam logic [15:0] HYST_MAX       = 16'h00C8;
    localparam logic [15:0] HYST_FULL      = 16'h03E8;
    localparam logic [15:0] OP_MIN_LOW     = 16'h0008;
    localparam logic [15:0] OP_MIN_MID     = 16'h0006;
    localparam logic [15:0] OP_MIN_HIGH    = 16'h0004;
    localparam logic [15:0] REL_MIN        = 16'h0006;
    localparam logic [15:0] DLY_MAX        = 16'h7530;

    // Timer tick: 10 ms delay resolution derived from the 4 ns clock period.
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned TICK_NS       = 10000000;
    localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

endpackage : ovp_pkg

// ===== design/ovp_set_mem.sv
// Setting store: four groups of per-stage settings with reset defaults.
// Assumes one writer and two independent readers, each read registered.
`timescale 1ns/1ns
`default_nettype none

module ovp_set_mem (
    // Clock and reset.
    input  wire logic                        clk_sys_i,
    input  wire logic                        nrst_i,
    // Write port.
    input  wire logic                        we_i,
    input  wire logic [ovp_pkg::MAW-1:0]     waddr_i,
    input  wire logic [ovp_pkg::DW-1:0]      wdata_i,
    // Read ports, data one cycle after the address.
    input  wire logic [ovp_pkg::MAW-1:0]     raddr_a_i,
    output logic      [ovp_pkg::DW-1:0]      rdata_a_o,
    input  wire logic [ovp_pkg::MAW-1:0]     raddr_b_i,
    output logic      [ovp_pkg::DW-1:0]      rdata_b_o
);

    // Word address type, declared before the entry compare that casts to it.
    typedef logic [ovp_pkg::MAW-1:0] ovp_waddr_t;

    // Storage words, one flip-flop group per entry so each has a defined reset value.
    logic [ovp_pkg::DW-1:0] mem_reg [1 << ovp_pkg::MAW];

    // Each entry resets to the default of the parameter it holds.
    genvar e;
    generate
        for (e = 0; e < (1 << ovp_pkg::MAW); e++)
        begin : g_ent
            localparam logic [1:0] PIDX = 2'(e);
            localparam logic [15:0] RST = (PIDX == ovp_pkg::PAR_START) ? ovp_pkg::START_RST :
                                          (PIDX == ovp_pkg::PAR_HYST)  ? ovp_pkg::HYST_RST  :
                                          (PIDX == ovp_pkg::PAR_OPDLY) ? ovp_pkg::OPDLY_RST :
                                                                         ovp_pkg::RELDLY_RST;
            always_ff @(posedge clk_sys_i or negedge nrst_i)
            begin
                if (!nrst_i)
                    mem_reg[e] <= RST;
                else if (we_i && (waddr_i == ovp_waddr_t'(e)))
                    mem_reg[e] <= wdata_i;
            end
        end
    endgenerate

    // Registered reads; a read of a word written in the same cycle returns the old value.
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rdata_a_o <= 16'h0000;
            rdata_b_o <= 16'h0000;
        end
        else
        begin
            rdata_a_o <= mem_reg[raddr_a_i];
            rdata_b_o <= mem_reg[raddr_b_i];
        end
    end

endmodule : ovp_set_mem

`default_nettype wire

// ===== design/ovp_top.sv
// Three-stage definite-time overvoltage protection with setting groups.
// Assumes line-to-line fundamental magnitudes in 0.01 V secondary, synchronous to clk_sys_i.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module ovp_top #(
    parameter int unsigned TICK_CYC = ovp_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic                    clk_sys_i,
    input  wire logic                    nrst_i,
    // Register port.
    input  wire logic [ovp_pkg::AW-1:0]  reg_addr_i,
    input  wire logic [ovp_pkg::DW-1:0]  reg_wdata_i,
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    output logic      [ovp_pkg::DW-1:0]  reg_rdata_o,
    // Line-to-line voltage magnitudes from the measurement chain.
    input  wire logic [15:0]             ll_volt_12_i,
    input  wire logic [15:0]             ll_volt_23_i,
    input  wire logic [15:0]             ll_volt_31_i,
    // Stage flags to the trip logic.
    output logic      [ovp_pkg::NST-1:0] start_o,
    output logic      [ovp_pkg::NST-1:0] trip_o
);

    // Control and rated secondary voltage registers.
    logic [15:0] ctrl_reg;
    logic [15:0] vnsec_reg;
    logic [1:0]  grp;
    logic [2:0]  stage_en;

    // Read path bookkeeping.
    logic        rd_set_reg;
    logic [15:0] misc_q_reg;
    logic [15:0] mem_q_a;
    logic [15:0] mem_q_b;

    // Setting scanner state.
    logic [3:0]  scan_idx_reg;
    logic [3:0]  scan_idx_d_reg;
    logic        scan_vld_reg;

    // Working copy of the active group's settings per stage.
    logic [15:0] wk_start [ovp_pkg::NST];
    logic [15:0] wk_hyst  [ovp_pkg::NST];
    logic [15:0] wk_op    [ovp_pkg::NST];
    logic [15:0] wk_rel   [ovp_pkg::NST];

    // Timer tick divider.
    logic [31:0] div_reg;
    logic        tick;

    assign grp      = ctrl_reg[ovp_pkg::CTRL_GRP_LSB +: 2];
    assign stage_en = ctrl_reg[ovp_pkg::CTRL_EN_LSB +: 3];

    // Software writes to control and rated voltage; settings go to the store.
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl_reg  <= ovp_pkg::CTRL_RST;
            vnsec_reg <= ovp_pkg::VNSEC_RST;
        end
        else if (reg_wr_i)
        begin
            if (reg_addr_i == ovp_pkg::REG_CTRL)
                ctrl_reg <= reg_wdata_i & 16'h001F;
            else if (reg_addr_i == ovp_pkg::REG_VNSEC)
                vnsec_reg <= reg_wdata_i & 16'h00FF;
        end
    end

    // Register reads answer one cycle later; unmapped addresses from 0x43 up read zero, while spare words 12 to 15 of each group read the store.
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rd_set_reg <= 1'b0;
            misc_q_reg <= 16'h0000;
        end
        else if (reg_rd_i)
        begin
            rd_set_reg <= (reg_addr_i < ovp_pkg::SET_END);
            if (reg_addr_i == ovp_pkg::REG_CTRL)
                misc_q_reg <= ctrl_reg;
            else if (reg_addr_i == ovp_pkg::REG_VNSEC)
                misc_q_reg <= vnsec_reg;
            else if (reg_addr_i == ovp_pkg::REG_STATUS)
                misc_q_reg <= 16'({trip_o, 1'b0, start_o});
            else
                misc_q_reg <= 16'h0000;
        end
        else
        begin
            rd_set_reg <= 1'b0;
            misc_q_reg <= 16'h0000;
        end
    end

    // Both sources are flip-flops, so the answer is registered data.
    assign reg_rdata_o = rd_set_reg ? mem_q_a : misc_q_reg;

    // Setting store: bus on port A, scanner on port B.
    ovp_set_mem u_set_mem (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .we_i      (reg_wr_i && (reg_addr_i < ovp_pkg::SET_END)),
        .waddr_i   (reg_addr_i[ovp_pkg::MAW-1:0]),
        .wdata_i   (reg_wdata_i),
        .raddr_a_i (reg_addr_i[ovp_pkg::MAW-1:0]),
        .rdata_a_o (mem_q_a),
        .raddr_b_i ({grp, scan_idx_reg}),
        .rdata_b_o (mem_q_b)
    );

    // The scanner walks the active group's twelve words forever, so a group change
    // or a setting write takes effect within fourteen cycles without any handshake.
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            scan_idx_reg   <= 4'h0;
            scan_idx_d_reg <= 4'h0;
            scan_vld_reg   <= 1'b0;
        end
        else
        begin
            scan_idx_reg   <= (scan_idx_reg == 4'hB) ? 4'h0 : scan_idx_reg + 4'h1;
            scan_idx_d_reg <= scan_idx_reg;
            scan_vld_reg   <= 1'b1;
        end
    end

    // Divider producing one tick every 10 ms for the delay timers.
    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            div_reg <= 32'h0000_0000;
        else if (div_reg >= TICK_CYC - 1)
            div_reg <= 32'h0000_0000;
        else
            div_reg <= div_reg + 32'h0000_0001;
    end

    assign tick = (div_reg >= TICK_CYC - 1);

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    // Each stage has its own settings, comparators and timers.
    genvar s;
    generate
        for (s = 0; s < ovp_pkg::NST; s++)
        begin : g_stg
            localparam logic [15:0] START_MAX = (s == 2) ? ovp_pkg::START_MAX_HIGH : ovp_pkg::START_MAX_LOW;
            localparam logic [15:0] OP_MIN    = (s == 0) ? ovp_pkg::OP_MIN_LOW :
                                                (s == 1) ? ovp_pkg::OP_MIN_MID : ovp_pkg::OP_MIN_HIGH;
            localparam bit          HAS_REL   = (s == 0);

            logic [15:0] start_eff;
            logic [15:0] hyst_eff;
            logic [15:0] op_eff;
            logic [15:0] rel_eff;
            logic [15:0] thr;
            logic [31:0] thr_rel;
            logic        over;
            logic        hold;
            logic        fault_reg;
            logic        start_reg;
            logic        trip_reg;
            logic [15:0] op_cnt_reg;
            logic [15:0] rel_cnt_reg;
            logic        rel_wait;

            // Load this stage's words as the scanner passes them.
            always_ff @(posedge clk_sys_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    wk_start[s] <= ovp_pkg::START_RST;
                    wk_hyst[s]  <= ovp_pkg::HYST_RST;
                    wk_op[s]    <= ovp_pkg::OPDLY_RST;
                    wk_rel[s]   <= ovp_pkg::RELDLY_RST;
                end
                else if (scan_vld_reg && (scan_idx_d_reg[3:2] == 2'(s)))
                begin
                    case (scan_idx_d_reg[1:0])
                        ovp_pkg::PAR_START: wk_start[s] <= mem_q_b;
                        ovp_pkg::PAR_HYST:  wk_hyst[s]  <= mem_q_b;
                        ovp_pkg::PAR_OPDLY: wk_op[s]    <= mem_q_b;
                        default:            wk_rel[s]   <= mem_q_b;
                    endcase
                end
            end

            // Out-of-range settings are pulled to the nearest legal value.
            assign start_eff = (wk_start[s] < ovp_pkg::START_MIN) ? ovp_pkg::START_MIN :
                               (wk_start[s] > START_MAX) ? START_MAX : wk_start[s];
            assign hyst_eff  = (wk_hyst[s] < ovp_pkg::HYST_MIN) ? ovp_pkg::HYST_MIN :
                               (wk_hyst[s] > ovp_pkg::HYST_MAX) ? ovp_pkg::HYST_MAX : wk_hyst[s];
            assign op_eff    = (wk_op[s] < OP_MIN) ? OP_MIN :
                               (wk_op[s] > ovp_pkg::DLY_MAX) ? ovp_pkg::DLY_MAX : wk_op[s];
            assign rel_eff   = (wk_rel[s] < ovp_pkg::REL_MIN) ? ovp_pkg::REL_MIN :
                               (wk_rel[s] > ovp_pkg::DLY_MAX) ? ovp_pkg::DLY_MAX : wk_rel[s];

            // Percent times rated volts gives 0.01 V; the input range caps it at 160 V.
            always_comb
            begin
                logic [15:0] prod;
                prod = start_eff[7:0] * vnsec_reg[7:0];
                thr  = (prod > ovp_pkg::MEAS_LIMIT) ? ovp_pkg::MEAS_LIMIT : prod;
            end

            // Release point in thousandths: threshold times (1000 - hysteresis).
            assign thr_rel = thr * (ovp_pkg::HYST_FULL - hyst_eff);

            // Only line-to-line inputs exist, so earth-fault neutral shifts cannot start a stage.
            assign over = (ll_volt_12_i > thr) || (ll_volt_23_i > thr) || (ll_volt_31_i > thr);
            assign hold = ((ll_volt_12_i * 32'd1000) >= thr_rel) ||
                          ((ll_volt_23_i * 32'd1000) >= thr_rel) ||
                          ((ll_volt_31_i * 32'd1000) >= thr_rel);

            // Only the low stage waits out a release delay once the fault clears.
            assign rel_wait = HAS_REL && start_reg && !fault_reg && (rel_cnt_reg < rel_eff);

            // Fault detector with hysteresis.
            always_ff @(posedge clk_sys_i or negedge nrst_i)
            begin
                if (!nrst_i)
                    fault_reg <= 1'b0;
                else if (!stage_en[s])
                    fault_reg <= 1'b0;
                else
                    fault_reg <= over || (fault_reg && hold);
            end

            // Start, trip and delay timers of the fixed_delay_characteristic.
            always_ff @(posedge clk_sys_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    start_reg   <= 1'b0;
                    trip_reg    <= 1'b0;
                    op_cnt_reg  <= 16'h0000;
                    rel_cnt_reg <= 16'h0000;
                end
                else if (!stage_en[s])
                begin
                    start_reg   <= 1'b0;
                    trip_reg    <= 1'b0;
                    op_cnt_reg  <= 16'h0000;
                    rel_cnt_reg <= 16'h0000;
                end
                else if (fault_reg)
                begin
                    // A fault returning during the low stage's release wait keeps the accumulated operate time.
                    start_reg   <= 1'b1;
                    rel_cnt_reg <= 16'h0000;
                    if (op_cnt_reg >= op_eff)
                        trip_reg <= 1'b1;
                    else if (tick)
                        op_cnt_reg <= op_cnt_reg + 16'h0001;
                end
                else if (rel_wait)
                begin
                    if (tick)
                        rel_cnt_reg <= rel_cnt_reg + 16'h0001;
                end
                else
                begin
                    start_reg   <= 1'b0;
                    trip_reg    <= 1'b0;
                    op_cnt_reg  <= 16'h0000;
                    rel_cnt_reg <= 16'h0000;
                end
            end

            assign start_o[s] = start_reg;
            assign trip_o[s]  = trip_reg;

            // A started stage clears once its fault is gone and, on the low stage only, its release has fully run out.
            sequence seq_release_done;
                !fault_reg && start_reg && !rel_wait;
            endsequence

            // What a cleared stage looks like on the edge after its release.
            sequence seq_stage_clear;
                !start_reg && !trip_reg && (op_cnt_reg == 16'h0000);
            endsequence

            a_start_on_over: assert property (stage_en[s] && over ##1 stage_en[s] |=> start_reg)
                else $error("stage did not start on overvoltage");
            a_trip_after_delay: assert property ($rose(trip_reg) |-> op_cnt_reg >= op_eff && $past(fault_reg))
                else $error("trip raised before operate delay");
            a_hyst_holds: assert property (stage_en[s] && fault_reg && hold |=> fault_reg)
                else $error("fault dropped above release point");
            a_timer_kept: assert property (stage_en[s] && rel_wait |=> $stable(op_cnt_reg))
                else $error("operate timer changed during release wait");
            a_release_clear: assert property ((stage_en[s] and seq_release_done) |=> seq_stage_clear)
                else $error("release did not clear stage");
            a_thr_limit: assert property (thr <= ovp_pkg::MEAS_LIMIT && start_eff <= START_MAX)
                else $error("threshold above measurement range");
            a_hyst_range: assert property (hyst_eff >= ovp_pkg::HYST_MIN && hyst_eff <= ovp_pkg::HYST_MAX)
                else $error("hysteresis outside range");
            // A disabled stage drops its flags on the next edge, whatever the other stages do.
            a_stage_off: assert property (!stage_en[s] |=> !start_reg && !trip_reg)
                else $error("disabled stage kept its flags");
            // Once tripped, a stage stays tripped for as long as the fault lasts.
            a_trip_held: assert property (stage_en[s] && trip_reg && fault_reg |=> trip_reg)
                else $error("trip dropped while fault present");
            if (!HAS_REL)
            begin : g_norel
                a_fast_clear: assert property (stage_en[s] && !fault_reg ##1 !fault_reg |-> !start_reg)
                    else $error("upper stage held start without fault");
            end
        end
    endgenerate

    // A group change followed by sixteen quiet cycles, long enough for a full scanner pass.
    sequence seq_group_settle;
        $changed(grp) && !reg_wr_i ##1 ($stable(grp) && !reg_wr_i) [*8] ##1 ($stable(grp) && !reg_wr_i) [*8];
    endsequence

    // The low stage's working start level must then be the new group's stored word.
    a_group_load: assert property (seq_group_settle |-> wk_start[0] == u_set_mem.mem_reg[{grp, 4'h0}])
        else $error("group change not followed");

endmodule : ovp_top

`default_nettype wire

// ===== verification/ovp_meas_src.sv
// Measurement chain model: three line-to-line magnitudes, at most one of them raised.
// Assumes the bench selects the raised line and its level on clk_sys_i.
`timescale 1ns/1ns
`default_nettype none

module ovp_meas_src (
    // Clock.
    input  wire logic        clk_sys_i,
    // Which line carries the raised level (3 means none) and the level.
    input  wire logic [1:0]  fault_line_i,
    input  wire logic [15:0] fault_lvl_i,
    // Magnitudes towards the protection block.
    output logic      [15:0] ll_volt_12_o,
    output logic      [15:0] ll_volt_23_o,
    output logic      [15:0] ll_volt_31_o
);
    // Healthy lines sit at 100.00 V, well clear of every release point.
    localparam logic [15:0] NOMINAL = 16'h2710;

    // Registered like a real filter output, so values move only on edges.
    always_ff @(posedge clk_sys_i)
    begin
        ll_volt_12_o <= (fault_line_i == 2'h0) ? fault_lvl_i : NOMINAL;
        ll_volt_23_o <= (fault_line_i == 2'h1) ? fault_lvl_i : NOMINAL;
        ll_volt_31_o <= (fault_line_i == 2'h2) ? fault_lvl_i : NOMINAL;
    end
endmodule : ovp_meas_src

`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the three-stage overvoltage block.
// Assumes a 4-cycle timer tick so that every delay fits in a short run.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    logic                    clk_sys_i;   // 250 MHz clock.
    logic                    nrst_i;      // Active-low reset.
    logic [ovp_pkg::AW-1:0]  reg_addr_i;  // Register address.
    logic [ovp_pkg::DW-1:0]  reg_wdata_i; // Register write data.
    logic                    reg_wr_i;    // Write strobe.
    logic                    reg_rd_i;    // Read strobe.
    logic [ovp_pkg::DW-1:0]  reg_rdata_o; // Read data.
    logic [15:0]             v12, v23, v31; // Line magnitudes.
    logic [2:0]              start_o;     // Stage starts.
    logic [2:0]              trip_o;      // Stage trips.
    logic [1:0]              f_line;      // Raised line select.
    logic [15:0]             f_lvl;       // Raised line level.
    logic [15:0]             exp_q[$];    // Expected read data, oldest first.
    logic                    rd_d;        // Read strobe seen one edge ago.
    int                      n_mismatch;  // Mismatch count.
    int                      checks_done; // Comparison count.

    // Short tick keeps trip delays to tens of cycles.
    ovp_top #(.TICK_CYC(4)) i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ll_volt_12_i(v12),
        .ll_volt_23_i(v23), .ll_volt_31_i(v31), .start_o(start_o), .trip_o(trip_o));
    ovp_meas_src i_src (.clk_sys_i(clk_sys_i), .fault_line_i(f_line),
        .fault_lvl_i(f_lvl), .ll_volt_12_o(v12), .ll_volt_23_o(v23), .ll_volt_31_o(v31));

    // Clock generator.
    initial
    begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    // Prints the verdict and stops.
    task automatic end_sim();
        if (n_mismatch == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    // Compares one value; both are 16 bits wide.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One-cycle write strobe.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    // One-cycle read strobe; the monitor checks the answer.
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys_i);
        reg_rd_i   <= 1'b0;
    endtask : rd

    // Bounded wait for one start or trip bit to reach a level.
    task automatic wait_for(input int s, input bit trp, input logic v, input int lim);
        int i;
        for (i = 0; i < lim; i++)
        begin
            @(posedge clk_sys_i);
            #1;
            if ((trp ? trip_o[s] : start_o[s]) === v)
                return;
        end
        n_mismatch++;
        $display("[ERR] %0t timeout %h %h", $time, {trip_o, start_o}, v);
        end_sim();
    endtask : wait_for

    // Read data stand only in the cycle after the strobe, so sample there.
    always @(posedge clk_sys_i)
    begin
        rd_d <= reg_rd_i;
        if (rd_d === 1'b1)
            chk(reg_rdata_o, exp_q.pop_front());
    end

    // Moves the raised line; the source registers it on the next edge.
    task automatic volt(input logic [1:0] l, input logic [15:0] v);
        @(posedge clk_sys_i);
        f_line <= l;
        f_lvl  <= v;
    endtask : volt

    initial
    begin
        logic [15:0] rst_v[4];
        logic [1:0]  ln;
        rst_v = '{ovp_pkg::START_RST, ovp_pkg::HYST_RST, ovp_pkg::OPDLY_RST, ovp_pkg::RELDLY_RST};
        {nrst_i, reg_wr_i, reg_rd_i} = 3'h0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 16'h0000;
        f_line = 2'h3;
        f_lvl = 16'h0000;
        n_mismatch = 0;
        checks_done = 0;
        void'($urandom(32'hb338_7a7a));
        repeat (20) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        // Reset values of control, rated voltage and the first four setting words, unmapped and status reads.
        rd(ovp_pkg::REG_CTRL, ovp_pkg::CTRL_RST);
        rd(ovp_pkg::REG_VNSEC, ovp_pkg::VNSEC_RST);
        for (int p = 0; p < 4; p++) rd(8'(p), rst_v[p]);
        rd(8'h50, 16'h0000);
        rd(ovp_pkg::REG_STATUS, 16'h0000);
        // Shortest operate delays, one per stage.
        wr(8'h02, ovp_pkg::OP_MIN_LOW);
        wr(8'h06, ovp_pkg::OP_MIN_MID);
        wr(8'h0A, ovp_pkg::OP_MIN_HIGH);
        rd(8'h0A, ovp_pkg::OP_MIN_HIGH);
        repeat (16) @(posedge clk_sys_i);
        // Any single raised line starts all stages; trips follow delay order.
        ln = 2'($urandom % 3);
        volt(ln, 16'(11001 + $urandom % 2000));
        wait_for(0, 1'b0, 1'b1, 8);
        chk(16'(start_o), 16'h0007);
        chk(16'(trip_o), 16'h0000);
        wait_for(2, 1'b1, 1'b1, 40);
        chk(16'(trip_o), 16'h0004);
        wait_for(1, 1'b1, 1'b1, 20);
        chk(16'(trip_o[0]), 16'h0000);
        wait_for(0, 1'b1, 1'b1, 20);
        rd(ovp_pkg::REG_STATUS, 16'h0077);
        // Inside the 3 % band the stages hold; below it they release.
        volt(ln, 16'd10700);
        repeat (20) @(posedge clk_sys_i);
        #1 chk(16'(start_o), 16'h0007);
        volt(ln, 16'd10600);
        wait_for(2, 1'b0, 1'b0, 8);
        chk(16'(start_o[0]), 16'h0001);
        wait_for(0, 1'b0, 1'b0, 40);
        chk(16'(trip_o), 16'h0000);
        // Intermittent fault: the low stage resumes its retained count.
        wr(8'h02, 16'h0014);
        volt(2'h0, 16'd11500);
        wait_for(0, 1'b0, 1'b1, 8);
        repeat (40) @(posedge clk_sys_i);
        volt(2'h3, 16'd0);
        repeat (8) @(posedge clk_sys_i);
        #1 chk(16'({start_o[0], trip_o[0]}), 16'h0002);
        volt(2'h1, 16'd11500);
        wait_for(0, 1'b1, 1'b1, 60);
        volt(2'h3, 16'd0);
        wait_for(0, 1'b0, 1'b0, 60);
        // Group 1: raised middle start, raised high start, clamp at 160 V.
        wr(8'h14, 16'h0096);
        wr(8'h18, 16'h00A0);
        wr(ovp_pkg::REG_VNSEC, 16'h00A0);
        wr(ovp_pkg::REG_CTRL, 16'hFFFD);
        rd(ovp_pkg::REG_CTRL, 16'h001D);
        volt(2'h2, 16'd16001);
        repeat (20) @(posedge clk_sys_i);
        #1 chk(16'(start_o), 16'h0007);
        volt(2'h2, 16'd15600);
        repeat (10) @(posedge clk_sys_i);
        #1 chk(16'(start_o), 16'h0007);
        // Disabling the low stage alone leaves the other two started.
        wr(ovp_pkg::REG_CTRL, 16'h0019);
        repeat (4) @(posedge clk_sys_i);
        #1 chk(16'(start_o), 16'h0006);
        end_sim();
    end
endmodule : tb_top

`default_nettype wire
